//--- rtl/opp_ctrl.sv
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - record constant current only after programmed delay
// - overcurrent trip waits for same delay
// - latched mode: low input disables, clear releases
// - follow mode: output disabled while input low
// - off mode: inhibit input does not disable output, but low input still blocks clear
// - shutoff mode kept in nonvolatile store
// - enabled protection trips on constant current
// - one protection enable for all channels
// - immediate current level sets the limit
// - overcurrent cleared by clear after cause gone
// - pending current applied on trigger when armed
// - data drives pins only in general io
// - bits 0,1 drive pins 1,2; reset zero
// - bit 2 high makes pin 3 input
// - read returns written bits, follow_shutoff_mode pin 3
// - port function selectable, kept nonvolatile
// - immediate and pending resistance, reset zero
// - clear needs all causes gone, restores state
module opp_ctrl
  import opp_pkg::*;
#(
  parameter int unsigned UNIT_CYC = UNIT_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [31:0] rd_data_o,
  output logic irq_o,
  // measurement and output control
  input wire logic [15:0] meas_curr_i,
  output logic out_en_o,
  output logic cc_state_o,
  output logic overcurrent_flag_o,
  output logic [15:0] curr_level_o,
  output logic [15:0] res_level_o,
  // control port pins 1..3
  input wire logic [2:0] port_pin_i,
  output logic [2:0] port_pin_o,
  output logic [2:0] port_pin_oe_o,
  // nonvolatile settings store
  input wire logic [3:0] nv_restore_i,
  output logic nv_store_o,
  output logic [3:0] nv_data_o
);

  opp_state_t s;
  opp_state_t n;

  logic inhibit_input;
  logic cc_raw;
  logic unit_tick;
  logic wr_ctrl;
  logic clr_cmd;
  logic clear_ok;
  logic trig_req;
  logic trig_take;
  logic reprog;
  logic [2:0] events;

  // inhibit input is pin 3 in shutoff/fault configuration, active low
  assign inhibit_input = (s.port_cfg == CFG_SHUTOFF) ? port_pin_i[2] : 1'b1;
  assign cc_raw = (meas_curr_i >= s.curr_imm);
  assign unit_tick = (s.unit_cnt == 17'(UNIT_CYC - 1));
  assign wr_ctrl = wr_en_i && (addr_i == ADDR_CTRL);
  assign clr_cmd = wr_en_i && (addr_i == ADDR_CMD) && wr_data_i[CMD_CLEAR];
  assign clear_ok = !cc_raw && inhibit_input;
  assign trig_req = (wr_en_i && (addr_i == ADDR_CMD) && wr_data_i[CMD_TRIG])
                    || ((s.port_cfg == CFG_TRIG) && port_pin_i[2] && !s.pin3_q);
  assign trig_take = trig_req && s.armed;
  assign reprog = trig_take
                  || (wr_en_i && (addr_i == ADDR_CURR_IMM || addr_i == ADDR_RES_IMM))
                  || (wr_ctrl && (wr_data_i[CTRL_OUT_ON] != s.out_on));

  always_comb begin
    n = s;
    n.rd_data = 32'h0000_0000;
    n.nv_store = 1'b0;
    events = 3'h0;
    n.pin3_q = port_pin_i[2];
    // restore stored settings once after reset release
    if (!s.nv_loaded) begin
      n.nv_loaded = 1'b1;
      n.mode = opp_mode_t'(nv_restore_i[1:0]);
      n.port_cfg = opp_cfg_t'(nv_restore_i[3:2]);
    end
    if (wr_en_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          n.out_on = wr_data_i[CTRL_OUT_ON];
          n.ocp_en = wr_data_i[CTRL_OCP_EN];
          if (wr_data_i[CTRL_MODE_LO +: 2] != 2'b11) begin
            n.mode = opp_mode_t'(wr_data_i[CTRL_MODE_LO +: 2]);
          end
          if (wr_data_i[CTRL_CFG_LO +: 2] != 2'b11) begin
            n.port_cfg = opp_cfg_t'(wr_data_i[CTRL_CFG_LO +: 2]);
          end
          n.armed = s.armed | wr_data_i[CTRL_ARM];
          n.nv_store = (n.mode != s.mode) || (n.port_cfg != s.port_cfg);
        end
        ADDR_DELAY: begin
          n.dly_ms = wr_data_i[30:0];
        end
        ADDR_CURR_IMM: begin
          n.curr_imm = wr_data_i[15:0];
        end
        ADDR_CURR_TRIG: begin
          n.curr_trig = wr_data_i[15:0];
        end
        ADDR_RES_IMM: begin
          n.res_imm = wr_data_i[15:0];
        end
        ADDR_RES_TRIG: begin
          n.res_trig = wr_data_i[15:0];
        end
        ADDR_DIG: begin
          n.dig = wr_data_i[2:0];
        end
        ADDR_INT_STAT: begin
          n.int_stat = s.int_stat & ~wr_data_i[2:0];
        end
        ADDR_INT_MASK: begin
          n.int_mask = wr_data_i[2:0];
        end
        default: begin
        end
      endcase
    end
    // armed trigger copies pending levels and disarms
    if (trig_take) begin
      n.curr_imm = s.curr_trig;
      n.res_imm = s.res_trig;
      n.armed = 1'b0;
      events[EV_TRIG] = 1'b1;
    end
    // delay counter in milliseconds, reloaded on every reprogramming
    if (reprog) begin
      n.dly_cnt = s.dly_ms;
      n.unit_cnt = 17'h0_0000;
    end else begin
      n.unit_cnt = unit_tick ? 17'h0_0000 : s.unit_cnt + 17'h0_0001;
      if (unit_tick && (s.dly_cnt != 31'h0000_0000)) begin
        n.dly_cnt = s.dly_cnt - 31'h0000_0001;
      end
    end
    if (!reprog && (s.dly_cnt == 31'h0000_0000)) begin
      n.cc_rec = cc_raw;
    end
    // overcurrent fault, set by the recorded state only
    if (clr_cmd && clear_ok) begin
      n.oc_flag = 1'b0;
      n.latch = 1'b0;
    end
    if (s.ocp_en && s.cc_rec) begin
      n.oc_flag = 1'b1;
      events[EV_OC] = !s.oc_flag;
    end
    if ((s.mode == MODE_LATCH) && !inhibit_input) begin
      n.latch = 1'b1;
      events[EV_LATCH] = !s.latch;
    end
    // out_on is untouched by faults, so clearing restores it
    n.out_en = s.out_on && !n.oc_flag
               && !((s.mode == MODE_LATCH) && n.latch)
               && !((s.mode == MODE_FOLLOW) && !inhibit_input);
    // port pins
    case (n.port_cfg)
      CFG_SHUTOFF: begin
        n.pin_out = {2'b00, n.oc_flag | n.latch};
        n.pin_oe = 3'b001;
      end
      CFG_GENIO: begin
        n.pin_out = {1'b0, n.dig[1:0]};
        n.pin_oe = {~n.dig[2], 2'b11};
      end
      default: begin
        n.pin_out = 3'b000;
        n.pin_oe = 3'b000;
      end
    endcase
    // sticky events, set wins over clear
    n.int_stat = n.int_stat | events;
    n.irq = |(n.int_stat & n.int_mask);
    if (rd_en_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          n.rd_data = {25'h0, s.armed, 2'(s.port_cfg), 2'(s.mode), s.ocp_en, s.out_on};
        end
        ADDR_DELAY: begin
          n.rd_data = {1'b0, s.dly_ms};
        end
        ADDR_CURR_IMM: begin
          n.rd_data = {16'h0000, s.curr_imm};
        end
        ADDR_CURR_TRIG: begin
          n.rd_data = {16'h0000, s.curr_trig};
        end
        ADDR_RES_IMM: begin
          n.rd_data = {16'h0000, s.res_imm};
        end
        ADDR_RES_TRIG: begin
          n.rd_data = {16'h0000, s.res_trig};
        end
        ADDR_DIG: begin
          n.rd_data = {29'h0, port_pin_i[2], s.dig[1:0]};
        end
        ADDR_STATUS: begin
          n.rd_data = {27'h0, s.armed, s.latch, s.oc_flag, s.cc_rec, s.out_en};
        end
        ADDR_INT_STAT: begin
          n.rd_data = {29'h0, s.int_stat};
        end
        ADDR_INT_MASK: begin
          n.rd_data = {29'h0, s.int_mask};
        end
        default: begin
          n.rd_data = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
      s.mode <= MODE_LATCH;
      s.port_cfg <= CFG_SHUTOFF;
      s.dly_ms <= DLY_RST_MS;
      s.curr_imm <= CURR_RST;
      s.curr_trig <= CURR_RST;
      s.res_imm <= RES_RST;
      s.res_trig <= RES_RST;
      s.dig <= DIG_RST;
      s.int_mask <= MASK_RST;
      s.pin_oe <= 3'b001;
    end else begin
      s <= n;
    end
  end

  assign rd_data_o = s.rd_data;
  assign irq_o = s.irq;
  assign out_en_o = s.out_en;
  assign cc_state_o = s.cc_rec;
  assign overcurrent_flag_o = s.oc_flag;
  assign curr_level_o = s.curr_imm;
  assign res_level_o = s.res_imm;
  assign port_pin_o = s.pin_out;
  assign port_pin_oe_o = s.pin_oe;
  assign nv_store_o = s.nv_store;
  assign nv_data_o = {2'(s.port_cfg), 2'(s.mode)};

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_latch_cause;
    s.nv_loaded && !wr_en_i && (s.mode == MODE_LATCH) && (s.port_cfg == CFG_SHUTOFF) && !port_pin_i[2];
  endsequence
  sequence s_latched_off;
    s.latch && !out_en_o;
  endsequence

  property p_cc_hold;
    (s.dly_cnt != 31'h0000_0000) |=> $stable(cc_state_o);
  endproperty
  a_cc_hold: assert property (p_cc_hold) else $error("cc status changed during delay");

  property p_reprog_hold;
    (reprog && s.dly_ms != 31'h0000_0000) |=> $stable(cc_state_o) ##1 $stable(cc_state_o);
  endproperty
  a_reprog_hold: assert property (p_reprog_hold) else $error("cc recorded too soon");

  property p_trip;
    (s.ocp_en && cc_state_o) |=> (overcurrent_flag_o && !out_en_o);
  endproperty
  a_trip: assert property (p_trip) else $error("overcurrent did not trip");

  property p_no_trip_off;
    (!s.ocp_en && !overcurrent_flag_o) |=> !overcurrent_flag_o;
  endproperty
  a_no_trip_off: assert property (p_no_trip_off) else $error("trip while disabled");

  property p_latch;
    s_latch_cause |=> s_latched_off;
  endproperty
  a_latch: assert property (p_latch) else $error("latched shutoff failed");

  property p_latch_keep;
    (s.latch && !(clr_cmd && clear_ok)) |=> s.latch;
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch released without clear");

  property p_follow;
    (!wr_en_i && s.mode == MODE_FOLLOW && s.port_cfg == CFG_SHUTOFF && !port_pin_i[2]) |=> !out_en_o;
  endproperty
  a_follow: assert property (p_follow) else $error("follow mode did not disable");

  property p_off_ignore;
    (s.nv_loaded && !wr_en_i && s.mode == MODE_OFF && s.out_on && !s.ocp_en && !s.oc_flag) |=> out_en_o;
  endproperty
  a_off_ignore: assert property (p_off_ignore) else $error("off mode disabled output");

  property p_unarmed;
    (!s.armed && !wr_en_i) |=> $stable(curr_level_o);
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("level changed without armed trigger");

  property p_genio;
    (s.port_cfg == CFG_GENIO && !wr_en_i)
      |=> (port_pin_o[1:0] == $past(s.dig[1:0])) && (port_pin_oe_o[2] == !$past(s.dig[2]));
  endproperty
  a_genio: assert property (p_genio) else $error("digital pins wrong");

  property p_trig_cfg;
    (s.port_cfg == CFG_TRIG && !wr_en_i) |=> (port_pin_oe_o == 3'b000);
  endproperty
  a_trig_cfg: assert property (p_trig_cfg) else $error("pins driven outside io mode");

endmodule : opp_ctrl
`default_nettype wire

//--- common/opp_pkg.sv
`default_nettype none
package opp_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam logic [7:0] ADDR_CURR_IMM = 8'h0C;
  localparam logic [7:0] ADDR_CURR_TRIG = 8'h10;
  localparam logic [7:0] ADDR_RES_IMM = 8'h14;
  localparam logic [7:0] ADDR_RES_TRIG = 8'h18;
  localparam logic [7:0] ADDR_DIG = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_INT_STAT = 8'h24;
  localparam logic [7:0] ADDR_INT_MASK = 8'h28;
  // control register fields
  localparam int CTRL_OUT_ON = 0;
  localparam int CTRL_OCP_EN = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_CFG_LO = 4;
  localparam int CTRL_ARM = 6;
  // command register fields (write-only pulses)
  localparam int CMD_CLEAR = 0;
  localparam int CMD_TRIG = 1;
  // interrupt event bits
  localparam int EV_OC = 0;
  localparam int EV_LATCH = 1;
  localparam int EV_TRIG = 2;
  // reset values and maximum current level
  localparam logic [15:0] CURR_MAX = 16'hFFFF;
  localparam logic [15:0] CURR_RST = 16'h1999;
  localparam logic [15:0] RES_RST = 16'h0000;
  localparam logic [2:0] DIG_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  // status-recording delay, counted in milliseconds
  localparam int CLK_MHZ = 125;
  localparam int DLY_UNIT_US = 1000;
  localparam int UNIT_CYCLES = CLK_MHZ * DLY_UNIT_US;
  localparam logic [30:0] DLY_RST_MS = 31'h0000_0050;
  localparam logic [30:0] DLY_MAX_MS = 31'h7FFF_FFFF;

  typedef enum logic [1:0] {
    MODE_LATCH = 2'b00,
    MODE_FOLLOW = 2'b01,
    MODE_OFF = 2'b10
  } opp_mode_t;

  typedef enum logic [1:0] {
    CFG_SHUTOFF = 2'b00,
    CFG_GENIO = 2'b01,
    CFG_TRIG = 2'b10
  } opp_cfg_t;

  typedef struct packed {
    logic out_on;
    logic ocp_en;
    opp_mode_t mode;
    opp_cfg_t port_cfg;
    logic armed;
    logic [30:0] dly_ms;
    logic [15:0] curr_imm;
    logic [15:0] curr_trig;
    logic [15:0] res_imm;
    logic [15:0] res_trig;
    logic [2:0] dig;
    logic [16:0] unit_cnt;
    logic [30:0] dly_cnt;
    logic cc_rec;
    logic oc_flag;
    logic latch;
    logic pin3_q;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [31:0] rd_data;
    logic irq;
    logic out_en;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic nv_store;
    logic nv_loaded;
  } opp_state_t;
endpackage : opp_pkg
`default_nettype wire

//--- dv/opp_ext_model.sv
`timescale 1ns/100ps
`default_nettype none
module opp_ext_model (
  // design side of the port
  input wire logic [2:0] port_pin_o,
  input wire logic [2:0] port_pin_oe_o,
  // far-side drivers
  input wire logic [2:0] ext_drv_i,
  input wire logic [2:0] ext_en_i,
  // resolved pin levels
  output logic [2:0] pin_lvl_o
);
  // a released pin floats to the pull-up level, the inactive inhibit state
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      pin_lvl_o[k] = port_pin_oe_o[k] ? port_pin_o[k] : (ext_en_i[k] ? ext_drv_i[k] : 1'b1);
    end
  end
endmodule : opp_ext_model
`default_nettype wire

//--- dv/opp_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module opp_ctrl_tb;
  import opp_pkg::*;
  localparam int unsigned UC = 4;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0000_0000;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [15:0] meas_curr_i = 16'h0000;
  logic [2:0] ext_drv = 3'h0;
  logic [2:0] ext_en = 3'h0;
  logic [2:0] pin_lvl;
  logic [31:0] rd_data_o;
  logic irq_o, out_en_o, cc_state_o, overcurrent_flag_o, nv_store_o;
  logic [15:0] curr_level_o, res_level_o;
  logic [2:0] port_pin_o, port_pin_oe_o, dv;
  logic [3:0] nv_data_o;
  logic [31:0] rdv;
  int num_errors = 0;
  int n_checks = 0;
  int nv_pulses = 0;
  int base, k;

  always #4 sys_clk_i = ~sys_clk_i;

  opp_ctrl #(.UNIT_CYC(UC)) opp_ctrl_inst (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
    .meas_curr_i(meas_curr_i), .out_en_o(out_en_o), .cc_state_o(cc_state_o),
    .overcurrent_flag_o(overcurrent_flag_o), .curr_level_o(curr_level_o), .res_level_o(res_level_o),
    .port_pin_i(pin_lvl), .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
    .nv_restore_i(4'h0), .nv_store_o(nv_store_o), .nv_data_o(nv_data_o)
  );

  opp_ext_model opp_ext_model_inst (
    .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
    .ext_drv_i(ext_drv), .ext_en_i(ext_en), .pin_lvl_o(pin_lvl)
  );

  always @(posedge sys_clk_i) begin
    if (nv_store_o === 1'b1) nv_pulses++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask : rd

  task automatic set_ext(input logic [2:0] d, input logic [2:0] e, input logic [15:0] m);
    @(posedge sys_clk_i);
    ext_drv <= d;
    ext_en <= e;
    meas_curr_i <= m;
    #1;
  endtask : set_ext

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    tick(1);
    chk(port_pin_oe_o, 32'h1, "pin dirs");
    chk(curr_level_o, CURR_RST, "curr imm");
    chk(res_level_o, RES_RST, "res imm");
    rd(ADDR_CTRL, rdv);
    chk(rdv, 32'h0, "ctrl");
    rd(ADDR_DELAY, rdv);
    chk(rdv, 32'h50, "delay");
    rd(ADDR_RES_TRIG, rdv);
    chk(rdv, 32'h0, "res pend");
    rd(ADDR_CURR_TRIG, rdv);
    chk(rdv, CURR_RST, "curr pend");
    rd(ADDR_DIG, rdv);
    chk(rdv, 32'h4, "dig");
    rd(8'h30, rdv);
    chk(rdv, 32'h0, "unmapped");
    $display("test reset done");
    // overcurrent trip after the recording delay; current rises only after the reload
    wr(ADDR_DELAY, 32'h2);
    wr(ADDR_CTRL, 32'h3);
    set_ext(3'h0, 3'h0, 16'hFFFF);
    tick(2 * UC - 3);
    chk(cc_state_o, 32'h0, "cc early");
    chk(out_en_o, 32'h1, "trip early");
    k = 0;
    while (cc_state_o !== 1'b1 && k < 12) begin
      tick(1);
      k++;
    end
    chk(cc_state_o, 32'h1, "cc late");
    tick(1);
    chk(overcurrent_flag_o, 32'h1, "oc flag");
    chk(out_en_o, 32'h0, "out off");
    chk(irq_o, 32'h0, "irq masked");
    rd(ADDR_STATUS, rdv);
    chk(rdv[3:0], 32'h6, "status");
    wr(ADDR_INT_MASK, 32'h1);
    tick(1);
    chk(irq_o, 32'h1, "irq");
    wr(ADDR_CMD, 32'h1);
    tick(1);
    chk(overcurrent_flag_o, 32'h1, "early clear");
    set_ext(3'h0, 3'h0, 16'h0000);
    tick(3);
    wr(ADDR_CMD, 32'h1);
    chk(overcurrent_flag_o, 32'h0, "clear");
    chk(out_en_o, 32'h1, "restore");
    wr(ADDR_INT_STAT, 32'h1);
    tick(1);
    chk(irq_o, 32'h0, "irq clr");
    $display("test ocp done");
    // shutoff modes
    wr(ADDR_CTRL, 32'h1);
    base = nv_pulses;
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CTRL, 32'(1 | (m << 2)));
      chk(nv_data_o, 32'(m), "nv data");
      set_ext(3'h0, 3'h4, 16'h0000);
      tick(2);
      chk(out_en_o, 32'(m == 2), "input low");
      set_ext(3'h0, 3'h0, 16'h0000);
      tick(2);
      chk(out_en_o, 32'(m != 0), "input high");
      wr(ADDR_CMD, 32'h1);
      tick(1);
      chk(out_en_o, 32'h1, "latch clear");
    end
    wr(ADDR_CTRL, 32'hD);
    rd(ADDR_CTRL, rdv);
    chk(rdv, 32'h9, "mode 3 refused");
    chk(32'(nv_pulses - base), 32'h2, "nv pulses");
    $display("test shutoff done");
    // pending values and triggers
    wr(ADDR_CURR_TRIG, 32'h1234);
    wr(ADDR_RES_TRIG, 32'h5);
    wr(ADDR_CMD, 32'h2);
    tick(1);
    chk(curr_level_o, CURR_RST, "unarmed");
    wr(ADDR_CTRL, 32'h49);
    wr(ADDR_CMD, 32'h2);
    tick(1);
    chk(curr_level_o, 32'h1234, "curr trig");
    chk(res_level_o, 32'h5, "res trig");
    rd(ADDR_STATUS, rdv);
    chk(rdv[4], 32'h0, "disarm");
    $display("test trigger done");
    // digital port
    wr(ADDR_DIG, 32'h3);
    chk(port_pin_o[2:1], 32'h0, "dig off");
    chk(port_pin_oe_o, 32'h1, "oe off");
    wr(ADDR_CTRL, 32'h19);
    for (int i = 0; i < 8; i++) begin
      dv = 3'(i);
      set_ext({~dv[0], 2'b00}, {dv[2], 2'b00}, 16'h0000);
      wr(ADDR_DIG, 32'(dv));
      tick(1);
      chk(port_pin_o[1:0], dv[1:0], "pins");
      chk(port_pin_oe_o, {~dv[2], 2'b11}, "pin3 dir");
      rd(ADDR_DIG, rdv);
      chk(rdv, {dv[2] & ~dv[0], dv[1:0]}, "dig rd");
    end
    $display("test digital done");
    // external trigger on a rising pin 3 in trigger configuration
    wr(ADDR_CURR_TRIG, 32'h777);
    wr(ADDR_CTRL, 32'h69);
    chk(port_pin_oe_o, 32'h0, "trig dirs");
    chk(curr_level_o, 32'h1234, "no edge yet");
    set_ext(3'h4, 3'h4, 16'h0000);
    tick(2);
    chk(curr_level_o, 32'h777, "ext trig");
    $display("test ext trigger done");
    tally_and_finish();
  end
endmodule : opp_ctrl_tb
`default_nettype wire
